// [design/serial_bit_clock.sv]
// bit clock: baud down-counter, oversample tick, bit tick, sync clock edges
// assumes syncClockIn comes straight from a pin
`timescale 1ns/100ps
module serial_bit_clock import serial_frame_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// configuration
	input wire logic [11:0] baudDiv,
	input wire logic baudLoad,
	input wire logic doubleSpeed,
	input wire logic syncMode,
	// external clock pin
	input wire logic syncClockIn,
	// ticks
	output logic osTick,
	output logic bitTick,
	output logic xckFall
);
	logic [11:0] baudCnt;
	logic [4:0] osCnt;
	logic xckMeta;
	logic xckSync;
	logic xckLast;
	logic [4:0] osPerBit;

	assign osPerBit = doubleSpeed ? OS_DOUBLE : OS_NORMAL;

	// reload on zero or on divisor write
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			baudCnt <= BAUD_RESET;
			osTick <= 1'b0;
		end else begin
			osTick <= (baudCnt == 12'h000) && !baudLoad;
			if (baudLoad || baudCnt == 12'h000)
				baudCnt <= baudDiv;
			else
				baudCnt <= baudCnt - 12'h001;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			xckMeta <= 1'b0;
			xckSync <= 1'b0;
			xckLast <= 1'b0;
		end else begin
			xckMeta <= syncClockIn;
			xckSync <= xckMeta;
			xckLast <= xckSync;
		end
	end

	// rate from divisor and double speed, or from the external clock
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			osCnt <= 5'h00;
			bitTick <= 1'b0;
			xckFall <= 1'b0;
		end else begin
			xckFall <= syncMode && xckLast && !xckSync;
			if (syncMode) begin
				bitTick <= xckSync && !xckLast;
				osCnt <= 5'h00;
			end else if (osTick) begin
				bitTick <= (osCnt >= osPerBit - 5'h01);
				osCnt <= (osCnt >= osPerBit - 5'h01) ? 5'h00 : osCnt + 5'h01;
			end else begin
				bitTick <= 1'b0;
			end
		end
	end
endmodule

// [design/serial_frame_pkg.sv]
// constants shared by the serial frame transmitter and its bit clock
// assumes a 32-bit apb master and a 200 MHz ref_clk
package serial_frame_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CTRL_B = 8'h08;
	localparam logic [7:0] OFS_CTRL_C = 8'h0c;
	localparam logic [7:0] OFS_BAUD = 8'h10;
	// status fields
	localparam int ST_DOUBLE = 1;
	localparam int ST_FRAME_ERR = 4;
	localparam int ST_BUF_EMPTY = 5;
	localparam int ST_TX_DONE = 6;
	localparam int ST_RX_DONE = 7;
	// ctrl_status_b fields
	localparam int CB_TX_NINTH = 0;
	localparam int CB_RX_NINTH = 1;
	localparam int CB_SIZE_HI = 2;
	localparam int CB_TX_EN = 3;
	localparam int CB_RX_EN = 4;
	// ctrl_status_c fields
	localparam int CC_SIZE_LO = 1;
	localparam int CC_STOP = 3;
	localparam int CC_PARITY = 4;
	localparam int CC_SYNC = 6;
	// reset values
	localparam logic [2:0] SIZE_RESET = 3'h3;
	localparam logic [1:0] PARITY_RESET = 2'h0;
	localparam logic [11:0] BAUD_RESET = 12'h000;
	// character size codes and parity modes
	localparam logic [2:0] SIZE_NINE = 3'h7;
	localparam logic [1:0] PARITY_EVEN = 2'h2;
	localparam logic [1:0] PARITY_ODD = 2'h3;
	// oversample ticks per bit
	localparam logic [4:0] OS_NORMAL = 5'h10;
	localparam logic [4:0] OS_DOUBLE = 5'h08;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP1 = 3'b100,
		TX_STOP2 = 3'b101
	} tx_state_type;
endpackage

// [design/serial_frame_transmitter.sv]
// serial frame transmitter with apb registers and a simple receive path
// assumes an apb master on ref_clk; rxd and the clock pin are asynchronous
//
// Summary of operation
// - all 30 formats: 5-9 data bits, none/even/odd parity, 1-2 stops
// - start bit first, then data bits least significant first
// - parity bit sits after last data bit, before first stop
// - after a frame, next frame follows at once or line idles high
// - one shared size, parity and stop setting for both directions
// - receiver ignores second stop; frame error only on low first stop
// - parity is xor of data bits, inverted for odd parity
// - transmitter enabled takes over the transmit pin
// - in sync mode the external clock pin clocks transmission
// - a data register write loads the buffer and starts sending
// - buffer moves to shifter when idle or right after last stop
// - shifter sends one frame at divisor/double-speed or pin rate
// - unused upper data bits are dropped for short characters
// - size code seven sends ninth bit from control register with byte
// - buffer-empty flag reads set whenever buffer can take data
// - receive-complete flag shows unread data in receive buffer
// - buffer-empty set when buffer empty, cleared by data write
// - tx-complete set when frame done, buffer empty; write one clears
// - disabling waits until shifter and buffer empty, then frees pin
`timescale 1ns/100ps
module serial_frame_transmitter import serial_frame_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pins
	output logic txdOut,
	output logic txdOe,
	input wire logic rxdIn,
	input wire logic syncClockIn
);
	logic [2:0] char_size_sel;
	logic [1:0] parity_mode_sel;
	logic stop_bits_sel, tx_enable_bit, rx_enable_bit, tx_ninth_bit;
	logic double_speed_bit, syncMode;
	logic [11:0] baudDiv;
	logic tx_complete_flag, rx_complete_flag, frame_error_flag;
	logic [8:0] bufData, frameData, rxShift, serial_data_reg;
	logic bufFull, txActive, parityBit, lastTick;
	logic [3:0] bitIdx, nData, rxNum, rxLast;
	tx_state_type state;
	logic osTick, bitTick, xckFall, rxdMeta, rxdSync;
	logic rxBusy, rxSample;
	logic [4:0] rxCnt, rxTarget;
	logic wrEn, rdEn, mapped;
	logic [8:0] sizeMask;

	assign wrEn = psel && penable && pready && pwrite;
	assign rdEn = psel && penable && !pready && !pwrite;
	assign mapped = paddr inside {OFS_DATA, OFS_STATUS, OFS_CTRL_B,
		OFS_CTRL_C, OFS_BAUD};

	// ------------------------------------------------------------
	// format decode
	// ------------------------------------------------------------
	always_comb begin
		unique case (char_size_sel)
		3'h0: nData = 4'd5;
		3'h1: nData = 4'd6;
		3'h2: nData = 4'd7;
		SIZE_NINE: nData = 4'd9;
		default: nData = 4'd8;
		endcase
	end
	assign sizeMask = 9'h1ff >> (4'd9 - nData);

	serial_bit_clock bitClock (
		.ref_clk(ref_clk),
		.reset(reset),
		.baudDiv(baudDiv),
		.baudLoad(wrEn && paddr == OFS_BAUD),
		.doubleSpeed(double_speed_bit),
		.syncMode(syncMode),
		.syncClockIn(syncClockIn),
		.osTick(osTick),
		.bitTick(bitTick),
		.xckFall(xckFall)
	);

	// ------------------------------------------------------------
	// apb slave, one wait state
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata <= 32'h0000_0000;
			if (rdEn) begin
				unique case (paddr)
				OFS_DATA: prdata[8:0] <= serial_data_reg;
				OFS_STATUS: prdata[7:0] <= {rx_complete_flag,
					tx_complete_flag, !bufFull, frame_error_flag,
					2'b00, double_speed_bit, 1'b0};
				OFS_CTRL_B: prdata[4:0] <= {rx_enable_bit,
					tx_enable_bit, char_size_sel[2],
					serial_data_reg[8], tx_ninth_bit};
				OFS_CTRL_C: prdata[6:0] <= {syncMode,
					parity_mode_sel, stop_bits_sel,
					char_size_sel[1:0], 1'b0};
				OFS_BAUD: prdata[11:0] <= baudDiv;
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			char_size_sel <= SIZE_RESET;
			parity_mode_sel <= PARITY_RESET;
			stop_bits_sel <= 1'b0;
			tx_enable_bit <= 1'b0;
			rx_enable_bit <= 1'b0;
			tx_ninth_bit <= 1'b0;
			double_speed_bit <= 1'b0;
			syncMode <= 1'b0;
			baudDiv <= BAUD_RESET;
		end else if (wrEn) begin
			if (paddr == OFS_STATUS)
				double_speed_bit <= pwdata[ST_DOUBLE];
			if (paddr == OFS_CTRL_B) begin
				rx_enable_bit <= pwdata[CB_RX_EN];
				tx_enable_bit <= pwdata[CB_TX_EN];
				char_size_sel[2] <= pwdata[CB_SIZE_HI];
				tx_ninth_bit <= pwdata[CB_TX_NINTH];
			end
			if (paddr == OFS_CTRL_C) begin
				syncMode <= pwdata[CC_SYNC];
				parity_mode_sel <= pwdata[CC_PARITY+:2];
				stop_bits_sel <= pwdata[CC_STOP];
				char_size_sel[1:0] <= pwdata[CC_SIZE_LO+:2];
			end
			if (paddr == OFS_BAUD)
				baudDiv <= pwdata[11:0];
		end
	end

	// ------------------------------------------------------------
	// transmit buffer and flags
	// ------------------------------------------------------------
	assign lastTick = bitTick && ((state == TX_STOP1 && !stop_bits_sel) ||
		state == TX_STOP2);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bufFull <= 1'b0;
			bufData <= 9'h000;
		end else if (wrEn && paddr == OFS_DATA) begin
			bufFull <= 1'b1;
			bufData <= {tx_ninth_bit, pwdata[7:0]} & sizeMask;
		end else if (txActive && bitTick &&
			(state == TX_IDLE || lastTick)) begin
			bufFull <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			tx_complete_flag <= 1'b0;
		else if (lastTick && !bufFull)
			tx_complete_flag <= 1'b1;
		else if (wrEn && paddr == OFS_STATUS && pwdata[ST_TX_DONE])
			tx_complete_flag <= 1'b0;
	end

	// disable waits for an empty shifter and buffer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			txActive <= 1'b0;
		else if (tx_enable_bit)
			txActive <= 1'b1;
		else if (state == TX_IDLE && !bufFull)
			txActive <= 1'b0;
	end

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= TX_IDLE;
			frameData <= 9'h000;
			parityBit <= 1'b0;
			bitIdx <= 4'h0;
		end else if (bitTick && txActive && bufFull &&
			(state == TX_IDLE || lastTick)) begin
			state <= TX_START;
			frameData <= bufData;
			parityBit <= ^bufData ^ (parity_mode_sel == PARITY_ODD);
			bitIdx <= 4'h0;
		end else if (bitTick) begin
			unique case (state)
			TX_IDLE: state <= TX_IDLE;
			TX_START: state <= TX_DATA;
			TX_DATA: begin
				bitIdx <= bitIdx + 4'h1;
				if (bitIdx == nData - 4'h1)
					state <= parity_mode_sel[1] ? TX_PARITY : TX_STOP1;
			end
			TX_PARITY: state <= TX_STOP1;
			TX_STOP1: state <= stop_bits_sel ? TX_STOP2 : TX_IDLE;
			TX_STOP2: state <= TX_IDLE;
			default: state <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			txdOut <= 1'b1;
			txdOe <= 1'b0;
		end else begin
			txdOe <= txActive;
			unique case (state)
			TX_START: txdOut <= 1'b0;
			TX_DATA: txdOut <= frameData[bitIdx];
			TX_PARITY: txdOut <= parityBit;
			default: txdOut <= 1'b1;
			endcase
		end
	end

	// ------------------------------------------------------------
	// receive path
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rxdMeta <= 1'b1;
			rxdSync <= 1'b1;
		end else begin
			rxdMeta <= rxdIn;
			rxdSync <= rxdMeta;
		end
	end

	assign rxTarget = (rxNum == 4'h0) ?
		((double_speed_bit ? OS_DOUBLE : OS_NORMAL) >> 1) - 5'h01 :
		(double_speed_bit ? OS_DOUBLE : OS_NORMAL) - 5'h01;
	assign rxSample = rxBusy && (syncMode ? xckFall :
		(osTick && rxCnt == rxTarget));
	assign rxLast = nData + {3'b000, parity_mode_sel[1]} + 4'h1;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rxBusy <= 1'b0;
			rxNum <= 4'h0;
			rxCnt <= 5'h00;
			rxShift <= 9'h000;
		end else if (!rx_enable_bit) begin
			rxBusy <= 1'b0;
		end else if (!rxBusy) begin
			rxBusy <= !rxdSync && (syncMode ? xckFall : osTick);
			rxNum <= 4'h0;
			rxCnt <= 5'h00;
			rxShift <= 9'h000;
		end else if (rxSample) begin
			rxCnt <= 5'h00;
			rxNum <= rxNum + 4'h1;
			if ((rxNum == 4'h0 && rxdSync) || rxNum == rxLast)
				rxBusy <= 1'b0;
			if (rxNum != 4'h0 && rxNum <= nData)
				rxShift[rxNum - 4'h1] <= rxdSync;
		end else if (osTick) begin
			rxCnt <= rxCnt + 5'h01;
		end
	end

	// first stop bit decides frame error; a second one is never sampled
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rx_complete_flag <= 1'b0;
			frame_error_flag <= 1'b0;
			serial_data_reg <= 9'h000;
		end else if (!rx_enable_bit) begin
			rx_complete_flag <= 1'b0;
		end else if (rxSample && rxNum == rxLast) begin
			rx_complete_flag <= 1'b1;
			frame_error_flag <= !rxdSync;
			serial_data_reg <= rxShift & sizeMask;
		end else if (rdEn && paddr == OFS_DATA) begin
			rx_complete_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_start_bit_low: assert property (
		$rose(state == TX_START) |=> !txdOut)
		else $error("start bit not driven low");
	a_parity_value: assert property (
		state == TX_PARITY |=> txdOut == $past(parityBit))
		else $error("parity slot carries wrong level");
	a_parity_calc: assert property (
		state == TX_PARITY |-> parityBit ==
		(^frameData ^ (parity_mode_sel == PARITY_ODD)))
		else $error("parity bit is not xor of data");
	a_stop_high: assert property (
		state == TX_STOP1 || state == TX_STOP2 |=> txdOut)
		else $error("stop bit not high");
	a_write_fills: assert property (
		wrEn && paddr == OFS_DATA |=> bufFull)
		else $error("data write did not fill buffer");
	a_done_sets: assert property (
		lastTick && !bufFull |=> tx_complete_flag)
		else $error("transmit complete not set");
	a_pin_release: assert property (
		$fell(txdOe) |-> $past(state == TX_IDLE && !bufFull, 2))
		else $error("pin released with work pending");
	a_enable_pin: assert property (
		tx_enable_bit |-> ##2 txdOe)
		else $error("enabled transmitter lacks pin");
	a_back_to_back: assert property (
		lastTick && bufFull && txActive |=> state == TX_START)
		else $error("buffered frame not started after stop");
	a_short_mask: assert property (
		bufFull && char_size_sel == 3'h0 |-> bufData[8:5] == 4'h0)
		else $error("upper bits kept for short character");
	a_apb_answer: assert property (
		psel && penable && !pready |=> pready)
		else $error("apb answer late");

	c_nine_bits: cover property (state == TX_DATA && bitIdx == 4'd8);
	c_two_stops: cover property (state == TX_STOP2 && bitTick);
	c_odd_parity: cover property (state == TX_PARITY &&
		parity_mode_sel == PARITY_ODD);
	c_rx_frame: cover property ($rose(rx_complete_flag));
endmodule

// [test/serial_peer_model.sv]
// remote serial peer: decodes transmit frames, sends receive frames
// assumes the bench sets bit length and format before each frame starts
`timescale 1ns/100ps
module serial_peer_model (
	// clock
	input wire logic ref_clk,
	// line from the transmitter
	input wire logic txdOut,
	input wire logic txdOe,
	// expected format
	input wire logic [7:0] bitClocks,
	input wire logic [3:0] nBits,
	input wire logic parOn,
	input wire logic twoStops,
	// decoded frame
	output logic [8:0] gotData,
	output logic gotPar,
	output logic [1:0] gotStop,
	output int gotCount,
	output int gotAt,
	// frame toward the receive pin, external clock run
	input wire logic [8:0] rxByte,
	input wire logic [7:0] rxGo,
	input wire logic rxStop,
	input wire logic syncRun,
	// lines driven back toward the device
	output logic rxdLine,
	output logic syncClk
);
	int cyc = 0;
	logic [7:0] rxGoSeen = 8'h00;
	logic [7:0] sCnt = 8'h00;

	// external clock stands low unless asked; one period per bit time
	always @(posedge ref_clk) begin
		if (!syncRun) begin
			syncClk <= 1'b0;
			sCnt <= 8'h00;
		end else if (sCnt >= bitClocks / 8'h02 - 8'h01) begin
			syncClk <= ~syncClk;
			sCnt <= 8'h00;
		end else begin
			sCnt <= sCnt + 8'h01;
		end
	end

	// receive line idles high; one frame per change of rxGo, no parity
	initial begin
		rxdLine <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (rxGo != rxGoSeen) begin
				rxGoSeen = rxGo;
				rxdLine <= 1'b0;
				repeat (bitClocks) @(posedge ref_clk);
				for (int i = 0; i < nBits; i++) begin
					rxdLine <= rxByte[i];
					repeat (bitClocks) @(posedge ref_clk);
				end
				rxdLine <= rxStop;
				repeat (bitClocks) @(posedge ref_clk);
				rxdLine <= 1'b1;
			end
		end
	end

	always @(posedge ref_clk) cyc <= cyc + 1;

	// ----------------------------------------
	// frame decoder, samples at mid bit
	// ----------------------------------------
	initial begin
		gotCount = 0;
		gotAt = 0;
		gotPar = 1'b0;
		gotStop = 2'b00;
		forever begin
			@(negedge ref_clk);
			if (txdOe === 1'b1 && txdOut === 1'b0) begin
				gotAt = cyc;
				gotData = 9'h000;
				repeat (bitClocks / 2) @(negedge ref_clk);
				for (int i = 0; i < nBits; i++) begin
					repeat (bitClocks) @(negedge ref_clk);
					gotData[i] = txdOut;
				end
				if (parOn) begin
					repeat (bitClocks) @(negedge ref_clk);
					gotPar = txdOut;
				end
				repeat (bitClocks) @(negedge ref_clk);
				gotStop[0] = txdOut;
				gotStop[1] = 1'b1;
				if (twoStops) begin
					repeat (bitClocks) @(negedge ref_clk);
					gotStop[1] = txdOut;
				end
				gotCount++;
			end
		end
	end
endmodule

// [test/testbench.sv]
// self-checking bench: apb master, format sweep, flags, disable
// assumes the peer model decodes every frame on the transmit line
`timescale 1ns/100ps
module testbench import serial_frame_pkg::*;;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, txdOut, txdOe, rxdLine, syncClk;
	logic [7:0] bitClocks = 8'h10;
	logic [3:0] nBits = 4'h8;
	logic parOn = 1'b0, twoStops = 1'b0, oddP = 1'b0, dbl = 1'b0;
	logic [8:0] gotData;
	logic gotPar;
	logic [1:0] gotStop;
	int gotCount, gotAt, seen = 0, failures = 0, nTests = 0;
	logic [31:0] seed = 32'h7944, ctrlB = 32'h0, q;
	logic e;
	logic [8:0] expQ[$];
	logic [8:0] rxByte = 9'h000;
	logic [7:0] rxGo = 8'h00;
	logic rxStop = 1'b1, syncRun = 1'b0;

	serial_frame_transmitter i_dut (.ref_clk(ref_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .txdOut(txdOut), .txdOe(txdOe),
		.rxdIn(rxdLine), .syncClockIn(syncClk));

	serial_peer_model i_peer (.ref_clk(ref_clk), .txdOut(txdOut),
		.txdOe(txdOe), .bitClocks(bitClocks), .nBits(nBits),
		.parOn(parOn), .twoStops(twoStops), .gotData(gotData),
		.gotPar(gotPar), .gotStop(gotStop), .gotCount(gotCount),
		.gotAt(gotAt), .rxByte(rxByte), .rxGo(rxGo), .rxStop(rxStop),
		.syncRun(syncRun), .rxdLine(rxdLine), .syncClk(syncClk));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) failures++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_status(input int b);
		int n;
		n = 0;
		q = 32'h0;
		while (q[b] !== 1'b1 && n < 2000) begin
			apb(1'b0, OFS_STATUS, 32'h0, q, e);
			n++;
		end
		if (n == 2000) failures++;
	endtask

	task automatic cfg(input logic [2:0] sz, input logic [1:0] pm,
		input logic st);
		nBits = (sz == SIZE_NINE) ? 4'h9 : 4'(sz) + 4'h5;
		parOn = pm[1];
		oddP = pm[0];
		twoStops = st;
		ctrlB = {28'h0, 1'b1, sz[2], 2'b00};
		apb(1'b1, OFS_CTRL_C, {26'h0, pm, st, sz[1:0], 1'b0}, q, e);
		apb(1'b1, OFS_CTRL_B, ctrlB, q, e);
	endtask

	task automatic clear_done();
		wait_status(ST_TX_DONE);
		apb(1'b1, OFS_STATUS, {25'h0, 1'b1, 4'h0, dbl, 1'b0}, q, e);
	endtask

	task automatic send(input logic [8:0] v);
		wait_status(ST_BUF_EMPTY);
		apb(1'b1, OFS_CTRL_B, ctrlB | {31'h0, v[8]}, q, e);
		apb(1'b1, OFS_DATA, {24'h0, v[7:0]}, q, e);
		expQ.push_back(v);
	endtask

	task automatic take_frame();
		int n;
		logic [8:0] v;
		logic [8:0] m;
		n = 0;
		while (gotCount == seen && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 4000) failures++;
		seen++;
		v = expQ.pop_front();
		m = 9'h1ff >> (4'h9 - nBits);
		chk("data", 32'(v & m), 32'(gotData));
		if (parOn) begin
			chk("parity", 32'(^(v & m) ^ oddP), 32'(gotPar));
		end
		chk("stop", 32'h3, 32'(gotStop));
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		wrap_up();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [2:0] sizes[5];
		logic [1:0] modes[3];
		int t1;
		int n;
		sizes = '{3'h0, 3'h1, 3'h2, 3'h3, SIZE_NINE};
		modes = '{PARITY_RESET, PARITY_EVEN, PARITY_ODD};
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		apb(1'b0, OFS_CTRL_C, 32'h0, q, e);
		chk("ctrl_c reset", {29'h0, SIZE_RESET[1:0], 1'b0}, q);
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		chk("status reset", 32'h20, q);
		chk("oe reset", 32'h0, 32'(txdOe));
		apb(1'b0, 8'h20, 32'h0, q, e);
		chk("unmapped err", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, q);
		apb(1'b1, OFS_BAUD, 32'h0, q, e);
		$display("test registers done");
		for (int s = 0; s < 5; s++) begin
			for (int p = 0; p < 3; p++) begin
				for (int t = 0; t < 2; t++) begin
					cfg(sizes[s], modes[p], t[0]);
					seed = xs(seed);
					send(seed[8:0]);
					take_frame();
					clear_done();
				end
			end
		end
		$display("test formats done");
		cfg(SIZE_RESET, PARITY_RESET, 1'b0);
		chk("oe on", 32'h1, 32'(txdOe));
		seed = xs(seed);
		send(seed[8:0]);
		seed = xs(seed);
		send(seed[8:0]);
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		chk("buffer full", 32'h0, 32'(q[ST_BUF_EMPTY]));
		chk("done early", 32'h0, 32'(q[ST_TX_DONE]));
		take_frame();
		t1 = gotAt;
		take_frame();
		chk("frame gap", 32'd160, 32'(gotAt - t1));
		clear_done();
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		chk("done cleared", 32'h0, 32'(q[ST_TX_DONE]));
		$display("test back to back done");
		apb(1'b1, OFS_CTRL_B, ctrlB | 32'h10, q, e);
		for (int k = 0; k < 2; k++) begin
			seed = xs(seed);
			rxByte <= seed[8:0];
			rxStop <= !k[0];
			rxGo <= rxGo + 8'h01;
			wait_status(ST_RX_DONE);
			chk("frame error", 32'(k[0]), 32'(q[ST_FRAME_ERR]));
			apb(1'b0, OFS_DATA, 32'h0, q, e);
			chk("rx data", 32'(seed[7:0]), q);
			apb(1'b0, OFS_STATUS, 32'h0, q, e);
			chk("rx done cleared", 32'h0, 32'(q[ST_RX_DONE]));
		end
		$display("test receive done");
		dbl = 1'b1;
		bitClocks = 8'h08;
		apb(1'b1, OFS_STATUS, 32'h2, q, e);
		seed = xs(seed);
		send(seed[8:0]);
		take_frame();
		clear_done();
		$display("test double speed done");
		apb(1'b1, OFS_CTRL_C, (32'h1 << CC_SYNC) | 32'h06, q, e);
		syncRun <= 1'b1;
		seed = xs(seed);
		send(seed[8:0]);
		take_frame();
		clear_done();
		syncRun <= 1'b0;
		apb(1'b1, OFS_CTRL_C, 32'h06, q, e);
		$display("test sync clock done");
		seed = xs(seed);
		send(seed[8:0]);
		apb(1'b1, OFS_CTRL_B, 32'h0, q, e);
		chk("oe held", 32'h1, 32'(txdOe));
		take_frame();
		clear_done();
		n = 0;
		while (txdOe !== 1'b0 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		chk("oe released", 32'h0, 32'(txdOe));
		chk("line idle", 32'h1, 32'(txdOut));
		$display("test disable done");
		wrap_up();
	end
endmodule
